// >>> hdl/imd_params.svh
// Constants for the iterative multiply and divide unit
`ifndef IMD_PARAMS_SVH
`define IMD_PARAMS_SVH

// ****************************************************************
// Register byte offsets on the APB
// ****************************************************************
`define IMD_OFF_FUNC      8'h00
`define IMD_OFF_D         8'h04
`define IMD_OFF_Q         8'h08
`define IMD_OFF_R         8'h0C
`define IMD_OFF_STAT      8'h10

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define IMD_ST_LOOP       0
`define IMD_ST_TOG        1
`define IMD_ST_LPC        2
`define IMD_ST_SO         3

// ****************************************************************
// Special function codes
// ****************************************************************
`define IMD_FN_MUL_TWO_POS 10'h279
`define IMD_FN_MUL_ONE_POS 10'h27B
`define IMD_FN_MUL_TWO_NEG 10'h269
`define IMD_FN_MUL_ONE_NEG 10'h26B
`define IMD_FN_DIV_TWO_POS 10'h26C
`define IMD_FN_DIV_ONE_POS 10'h26E
`define IMD_FN_DIV_TWO_NEG 10'h27C
`define IMD_FN_DIV_ONE_NEG 10'h27E
`define IMD_FN_REM_ASSY    10'h26A
`define IMD_FN_DDIV_ADD    10'h27F
`define IMD_FN_DDIV_SUB    10'h26F
`define IMD_FN_ALUF_0      10'h37C
`define IMD_FN_ALUF_1      10'h37D
`define IMD_FN_ALUF_2      10'h37E
`define IMD_FN_ALUF_3      10'h37F

// Code bit telling one iteration per cycle from two
`define IMD_FN_RATE_BIT   1
// Code bit that carries the operand sign choice
`define IMD_FN_SIGN_BIT   4

// ****************************************************************
// Reset values
// ****************************************************************
`define IMD_RST_WORD      32'h0000_0000
`define IMD_RST_FUNC      10'h000

`endif

// >>> hdl/imd_pkg.sv
// Types shared by the iterative multiply and divide unit
package imd_pkg;
	typedef logic [31:0] imd_word_t;
	typedef logic [9:0]  imd_func_t;
	typedef enum logic [2:0] {
		IMD_OP_OTHER,
		IMD_OP_MUL,
		IMD_OP_DIV,
		IMD_OP_DDIV,
		IMD_OP_REM,
		IMD_OP_KEEP
	} imd_op_t;
endpackage : imd_pkg

// >>> hdl/imd_mul_div.sv
// Iterative multiply and divide datapath with an APB register port

`include "imd_params.svh"

module imd_mul_div
	import imd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             loop_active
);

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************
	function automatic imd_op_t classify(input imd_func_t f);
		case (f)
			`IMD_FN_MUL_TWO_POS, `IMD_FN_MUL_ONE_POS,
			`IMD_FN_MUL_TWO_NEG, `IMD_FN_MUL_ONE_NEG: begin
				classify = IMD_OP_MUL;
			end
			`IMD_FN_DIV_TWO_POS, `IMD_FN_DIV_ONE_POS,
			`IMD_FN_DIV_TWO_NEG, `IMD_FN_DIV_ONE_NEG: begin
				classify = IMD_OP_DIV;
			end
			`IMD_FN_DDIV_ADD, `IMD_FN_DDIV_SUB: begin
				classify = IMD_OP_DDIV;
			end
			`IMD_FN_REM_ASSY: begin
				classify = IMD_OP_REM;
			end
			`IMD_FN_ALUF_0, `IMD_FN_ALUF_1,
			`IMD_FN_ALUF_2, `IMD_FN_ALUF_3: begin
				classify = IMD_OP_KEEP;
			end
			default: begin
				classify = IMD_OP_OTHER;
			end
		endcase
	endfunction : classify

	// One multiply step; result is {d, q, tog, carry flag}
	function automatic logic [65:0] mul_iter(
		input imd_word_t d,
		input imd_word_t q,
		input logic      iteration_bit_flag,
		input imd_word_t r,
		input logic      neg
	);
		imd_word_t   addend;
		logic [32:0] sum;
		addend = iteration_bit_flag ? r : `IMD_RST_WORD;
		// Minus variants add the two's complement of the multiplicand
		sum = neg ? ({d[31], d} - {1'b0, addend})
			: ({1'b0, d} + {1'b0, addend});
		// D:Q shift right as one; ALU bit 0 enters Q and the carry flag
		mul_iter = {sum[32:1], sum[0], q[31:1], q[0], sum[0]};
	endfunction : mul_iter

	// One nonrestoring divide step; result is {d, q, tog, sign out}
	// D:Q holds the 64-bit dividend, R the 32-bit divisor
	function automatic logic [65:0] div_iter(
		input imd_word_t d,
		input imd_word_t q,
		input logic      iteration_bit_flag,
		input imd_word_t r,
		input logic      neg,
		input logic      setup
	);
		logic        sub;
		logic [32:0] alu;
		// A previous success asks for a subtract, a failure for an add
		sub = (setup | iteration_bit_flag) ^ neg;
		alu = sub ? ({1'b0, d} + {1'b0, ~r} + 33'h0_0000_0001)
			: ({1'b0, d} + {1'b0, r});
		// Carry out of bit 31 is the quotient bit
		div_iter = {alu[30:0], q[31], q[30:0], alu[32], alu[32],
			alu[31]};
	endfunction : div_iter

	// ****************************************************************
	// State
	// ****************************************************************
	imd_func_t func_r;
	imd_word_t d_r;
	imd_word_t q_r;
	imd_word_t r_r;
	logic      loop_r;
	logic      tog_r;
	logic      lpc_r;
	logic      so_r;

	imd_func_t func_nxt;
	imd_word_t d_nxt;
	imd_word_t q_nxt;
	imd_word_t r_nxt;
	logic      loop_nxt;
	logic      tog_nxt;
	logic      lpc_nxt;
	logic      so_nxt;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic      acc_wr;
	logic      setup_rd;
	logic      hit_func;
	logic      hit_d;
	logic      hit_q;
	logic      hit_r;
	logic      hit_stat;
	logic      addr_ok;
	logic      step;
	imd_word_t stat_word;
	imd_word_t rd_word;

	assign hit_func = (paddr == `IMD_OFF_FUNC);
	assign hit_d    = (paddr == `IMD_OFF_D);
	assign hit_q    = (paddr == `IMD_OFF_Q);
	assign hit_r    = (paddr == `IMD_OFF_R);
	assign hit_stat = (paddr == `IMD_OFF_STAT);
	assign addr_ok  = hit_func | hit_d | hit_q | hit_r | hit_stat;
	assign acc_wr   = psel & penable & pwrite;
	assign setup_rd = psel & ~penable;
	// Each write of a function code is one microcycle of that function
	assign step     = acc_wr & hit_func;
	assign pready   = psel & penable;

	always_comb begin
		stat_word              = `IMD_RST_WORD;
		stat_word[`IMD_ST_LOOP] = loop_r;
		stat_word[`IMD_ST_TOG]  = tog_r;
		stat_word[`IMD_ST_LPC]  = lpc_r;
		stat_word[`IMD_ST_SO]   = so_r;
	end

	assign rd_word = hit_func ? {22'h00_0000, func_r}
		: hit_d ? d_r
		: hit_q ? q_r
		: hit_r ? r_r
		: hit_stat ? stat_word
		: `IMD_RST_WORD;

	// ****************************************************************
	// Function classification of the code being issued
	// ****************************************************************
	imd_op_t op;
	logic    op_mul;
	logic    op_div;
	logic    op_rem;
	logic    fn_fast;
	logic    fn_neg;
	logic    mul_setup;

	assign op      = classify(pwdata[9:0]);
	assign op_mul  = step & (op == IMD_OP_MUL);
	assign op_div  = step & (op == IMD_OP_DIV);
	assign op_rem  = step & (op == IMD_OP_REM);
	assign fn_fast = ~pwdata[`IMD_FN_RATE_BIT];
	// Plus multiplies carry a one in the sign bit, plus divides a zero
	assign fn_neg  = (op == IMD_OP_DIV) ? pwdata[`IMD_FN_SIGN_BIT]
		: ~pwdata[`IMD_FN_SIGN_BIT];
	assign mul_setup = op_mul & ~loop_r;

	// ****************************************************************
	// Iteration chain: stage 1 is one step, stage 2 is two steps
	// ****************************************************************
	imd_word_t sd  [0:2];
	imd_word_t sq  [0:2];
	logic      stg [0:2];
	logic      sf  [0:2];

	assign sd[0]  = d_r;
	assign sq[0]  = q_r;
	assign stg[0] = tog_r;
	assign sf[0]  = (op == IMD_OP_DIV) ? so_r : lpc_r;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_iter
			logic [65:0] mres;
			logic [65:0] dres;
			assign mres = mul_iter(sd[gi], sq[gi], stg[gi], r_r, fn_neg);
			assign dres = div_iter(sd[gi], sq[gi], stg[gi], r_r, fn_neg,
				(gi == 0) && !loop_r);
			assign {sd[gi+1], sq[gi+1], stg[gi+1], sf[gi+1]} =
				(op == IMD_OP_DIV) ? dres : mres;
		end
	endgenerate

	// Set-up is always a single step, even for the fast variants
	logic      use_two;
	imd_word_t it_d;
	imd_word_t it_q;
	logic      it_tog;
	logic      it_f;

	assign use_two = fn_fast & loop_r;
	assign it_d    = use_two ? sd[2] : sd[1];
	assign it_q    = use_two ? sq[2] : sq[1];
	assign it_tog  = use_two ? stg[2] : stg[1];
	assign it_f    = use_two ? sf[2] : sf[1];

	// ****************************************************************
	// Remainder assembly
	// ****************************************************************
	imd_word_t rem_alu;
	imd_word_t rem_d;

	// Sign out re-enters at the top to undo the surplus left shift
	assign rem_alu = d_r - r_r;
	assign rem_d   = {so_r, rem_alu[31:1]};

	// ****************************************************************
	// Next state
	// ****************************************************************
	assign func_nxt = step ? pwdata[9:0] : func_r;
	assign r_nxt    = (acc_wr & hit_r) ? pwdata : r_r;

	assign d_nxt = (acc_wr & hit_d) ? pwdata
		: mul_setup ? `IMD_RST_WORD
		: (op_mul | op_div) ? it_d
		: op_rem ? rem_d
		: d_r;

	assign q_nxt = (acc_wr & hit_q) ? pwdata
		: mul_setup ? {1'b0, q_r[31:1]}
		: (op_mul | op_div) ? it_q
		: q_r;

	// Loop stays up through flag reads so status polls do not end it
	assign loop_nxt = !step ? loop_r
		: (op_mul | op_div) ? 1'b1
		: (op == IMD_OP_DDIV || op == IMD_OP_KEEP) ? loop_r
		: 1'b0;

	assign tog_nxt = mul_setup ? q_r[0]
		: (op_mul | op_div) ? it_tog
		: tog_r;

	assign lpc_nxt = mul_setup ? 1'b0
		: op_mul ? it_f
		: lpc_r;

	assign so_nxt = op_div ? it_f
		: op_rem ? rem_alu[0]
		: so_r;

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_r <= `IMD_RST_FUNC;
			d_r    <= `IMD_RST_WORD;
			q_r    <= `IMD_RST_WORD;
			r_r    <= `IMD_RST_WORD;
			loop_r <= 1'b0;
			tog_r  <= 1'b0;
			lpc_r  <= 1'b0;
			so_r   <= 1'b0;
		end else begin
			func_r <= func_nxt;
			d_r    <= d_nxt;
			q_r    <= q_nxt;
			r_r    <= r_nxt;
			loop_r <= loop_nxt;
			tog_r  <= tog_nxt;
			lpc_r  <= lpc_nxt;
			so_r   <= so_nxt;
		end
	end

	// Read data is caught in the setup phase so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= `IMD_RST_WORD;
			pslverr <= 1'b0;
		end else if (setup_rd) begin
			prdata  <= pwrite ? `IMD_RST_WORD : rd_word;
			pslverr <= ~addr_ok;
		end
	end

	assign loop_active = loop_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [32:0] chk_sum;
	logic        chk_slow_pos;
	logic        chk_fast;
	logic        chk_keep;

	assign chk_sum      = {1'b0, d_r} + {1'b0, tog_r ? r_r : 32'h0000_0000};
	assign chk_slow_pos = op_mul & loop_r & ~fn_fast & ~fn_neg;
	assign chk_fast     = op_mul & loop_r & fn_fast;
	assign chk_keep     = step & (op == IMD_OP_MUL || op == IMD_OP_DIV
		|| op == IMD_OP_DDIV || op == IMD_OP_KEEP);

	sequence s_mul_entry;
		op_mul && !loop_r;
	endsequence

	sequence s_slow_iter;
		op_mul && loop_r && !fn_fast;
	endsequence

	a_setup_clears: assert property (
		s_mul_entry |=> loop_r && d_r == 32'h0000_0000 && !lpc_r)
		else $error("multiply set-up did not clear D and carry");

	a_setup_tog_load: assert property (
		s_mul_entry |=> tog_r == $past(q_r[0]) && !q_r[31])
		else $error("multiply set-up flag or Q shift wrong");

	a_loop_clears: assert property (
		step && !chk_keep |=> !loop_r && !loop_active)
		else $error("loop flag kept by unrelated function");

	a_loop_holds: assert property (
		op_mul |=> loop_r)
		else $error("multiply loop interrupted");

	a_slow_q_shift: assert property (
		s_slow_iter |=> q_r[30:0] == $past(q_r[31:1])
			&& tog_r == $past(q_r[0]))
		else $error("slow multiply shifted Q wrongly");

	a_fast_q_shift: assert property (
		chk_fast |=> q_r[29:0] == $past(q_r[31:2])
			&& tog_r == $past(q_r[1]))
		else $error("fast multiply did not do two steps");

	a_add_shift_sum: assert property (
		chk_slow_pos |=> {d_r, q_r[31]} == $past(chk_sum))
		else $error("multiply add and shift result wrong");

	a_carry_follow: assert property (
		s_slow_iter |=> lpc_r == q_r[31])
		else $error("low product carry not from ALU bit 0");

	a_rem_sign_out: assert property (
		op_rem |=> so_r == ($past(d_r[0]) ^ $past(r_r[0]))
			&& d_r[31] == $past(so_r))
		else $error("remainder assembly shift wrong");

endmodule : imd_mul_div

// >>> testbench/imd_seq_model.sv
// Sequencer model: APB master, operand placement and step counter
`include "imd_params.svh"

module imd_seq_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] rdata;
	logic        rerr;

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'hFF;
		pwdata  = 32'h0000_0000;
	end

	// ****************************************************************
	// One APB transfer, held until pready is seen at a rising edge
	// ****************************************************************
	// Waits as long as it takes; only the bench watchdog ends a hang
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdata   = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released lines must not keep showing the old value
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask : xfer

	task automatic load(input logic [31:0] d, q, r);
		xfer(1'b1, `IMD_OFF_D, d);
		xfer(1'b1, `IMD_OFF_Q, q);
		xfer(1'b1, `IMD_OFF_R, r);
	endtask : load

	// Step counter; psel drops for one cycle between the counted writes
	task automatic run_loop(input logic [9:0] code, input int cycles);
		int cnt;
		cnt = cycles;
		while (cnt > 0) begin
			xfer(1'b1, `IMD_OFF_FUNC, {22'h0, code});
			cnt--;
		end
	endtask : run_loop

	// Remainder assembly wants a cleared operand bus
	task automatic rem_assy();
		xfer(1'b1, `IMD_OFF_R, 32'h0000_0000);
		xfer(1'b1, `IMD_OFF_FUNC, {22'h0, `IMD_FN_REM_ASSY});
	endtask : rem_assy
endmodule : imd_seq_model

// >>> testbench/tb_top.sv
// Self-checking bench for the iterative multiply and divide unit
`include "imd_params.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        loop_active;
	int          num_errors;
	int          check_count;
	logic [9:0]  mc [4] = '{`IMD_FN_MUL_TWO_POS, `IMD_FN_MUL_ONE_POS,
		`IMD_FN_MUL_TWO_NEG, `IMD_FN_MUL_ONE_NEG};
	logic [9:0]  dc [4] = '{`IMD_FN_DIV_TWO_POS, `IMD_FN_DIV_ONE_POS,
		`IMD_FN_DIV_TWO_NEG, `IMD_FN_DIV_ONE_NEG};

	imd_mul_div DUT (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.loop_active (loop_active)
	);

	imd_seq_model seq (
		.pclk    (pclk),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata)
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ****************************************************************
	// Checking helpers
	// ****************************************************************
	task automatic chk(input string nm, input logic [63:0] e, g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		seq.xfer(1'b0, a, 32'h0000_0000);
		v = seq.rdata;
	endtask : rd

	task automatic chk_reg(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(nm, {32'h0, e}, {32'h0, v});
	endtask : chk_reg

	// Let the write edge's updates land before looking
	task automatic chk_loop(input logic e);
		@(negedge pclk);
		chk("loop_active", {63'h0, e}, {63'h0, loop_active});
	endtask : chk_loop

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic mul_test(input logic [9:0] c, input logic [31:0] a, b);
		logic [63:0] p;
		logic [31:0] v;
		p = {32'h0, a} * {32'h0, b};
		if (!c[`IMD_FN_SIGN_BIT])
			p = -p;
		seq.load(32'h5A5A_5A5A, b, a);
		seq.run_loop(c, 1);
		chk_loop(1'b1);
		chk_reg("setup Q", `IMD_OFF_Q, {1'b0, b[31:1]});
		chk_reg("setup D", `IMD_OFF_D, 32'h0000_0000);
		chk_reg("issued code", `IMD_OFF_FUNC, {22'h0, c});
		rd(`IMD_OFF_STAT, v);
		chk("setup flags", {61'h0, 1'b0, b[0], 1'b1}, {61'h0, v[2:0]});
		seq.run_loop(c, c[`IMD_FN_RATE_BIT] ? 32 : 16);
		rd(`IMD_OFF_STAT, v);
		chk("carry flag", {63'h0, p[31]}, {63'h0, v[2]});
		chk_reg("product hi", `IMD_OFF_D, p[63:32]);
		chk_reg("product lo", `IMD_OFF_Q, p[31:0]);
		seq.xfer(1'b1, `IMD_OFF_FUNC, {22'h0, `IMD_FN_ALUF_0});
		chk_loop(1'b1);
		seq.xfer(1'b1, `IMD_OFF_FUNC, {22'h0, `IMD_FN_DDIV_ADD});
		chk_loop(1'b1);
		seq.xfer(1'b1, `IMD_OFF_FUNC, 32'h0000_0000);
		chk_loop(1'b0);
	endtask : mul_test

	task automatic div_test(input logic [9:0] c, input logic [31:0] r);
		logic [63:0] dd;
		logic [31:0] v;
		dd = 64'h0000_0123_4567_89AB;
		seq.load(dd[63:32], dd[31:0], c[`IMD_FN_SIGN_BIT] ? -r : r);
		seq.run_loop(c, c[`IMD_FN_RATE_BIT] ? 33 : 17);
		chk_loop(1'b1);
		chk_reg("quotient", `IMD_OFF_Q, 32'(dd / {32'h0, r}));
		seq.xfer(1'b1, `IMD_OFF_FUNC, 32'h0000_0000);
		chk_loop(1'b0);
		seq.rem_assy();
		rd(`IMD_OFF_D, v);
		// Last compare may have failed: the remainder is restored here
		if (v[31])
			v = v + r;
		chk("remainder", dd % {32'h0, r}, {32'h0, v});
	endtask : div_test

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	initial begin
		num_errors = 0;
		check_count = 0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++)
			chk_reg("reset value", 8'(4 * i), 32'h0000_0000);
		chk_loop(1'b0);
		seq.xfer(1'b1, `IMD_OFF_R, 32'hFFFF_FFFF);
		chk_reg("R word", `IMD_OFF_R, 32'hFFFF_FFFF);
		seq.xfer(1'b1, `IMD_OFF_STAT, 32'h0000_000F);
		chk_reg("status ro", `IMD_OFF_STAT, 32'h0000_0000);
		seq.xfer(1'b0, 8'h14, 32'h0000_0000);
		chk("unmapped err", 64'h1, {63'h0, seq.rerr});
		chk("unmapped data", 64'h0, {32'h0, seq.rdata});
		foreach (mc[i])
			mul_test(mc[i], 32'h7654_3210, 32'hF00D_1235);
		foreach (dc[i])
			div_test(dc[i], 32'h0000_1234);
		test_done();
	end

	// Whole run is under a thousand cycles; this cuts a hang short
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		test_done();
	end
endmodule : tb_top
